// file: had_bus_master.sv
// processor and PCI/ISA master model that issues one decode request at a time
`timescale 1ns/1ns
module had_bus_master (
	input  wire logic         i_clk,
	output had_pkg::had_req_t o_req
);
	import had_pkg::*;
	// idle lines until the first request
	initial begin
		o_req = '0;
	end
	// request stands one cycle after gap idle cycles; released lines show the inverse of the last value, except qual_n, which goes high
	task automatic issue(input logic mem, wr, cpu, qn, input logic [ADDR_W-1:0] a, input logic [7:0] d,
		input int gap);
		repeat (gap) @(posedge i_clk);
		@(posedge i_clk);
		o_req <= '{valid:1'b1, mem:mem, wr:wr, from_cpu:cpu, qual_n:qn, addr:a, wdata:d};
		@(posedge i_clk);
		o_req <= '{valid:1'b0, mem:~mem, wr:~wr, from_cpu:~cpu, qual_n:1'b1, addr:~a, wdata:~d};
		#1;
	endtask : issue
endmodule : had_bus_master

// file: had_io_dec.sv
// legacy I/O port decoder
`timescale 1ns/1ns
module had_io_dec (
	input  wire logic [15:0]     i_port,
	output had_pkg::had_io_t     o_io
);
	import had_pkg::*;

	// match one port against the legacy map, aliases folded by masks
	function automatic had_io_t io_map(input logic [15:0] p);
		had_io_t r;
		r = IO_NONE;
		if ((p & M_DMA1) == P_DMA1) begin
			r = IO_DMA1;
		end else if ((p & M_PAIR) == P_SIO) begin
			r = ((p & IO_ODD) != '0) ? IO_SIO_DAT : IO_SIO_IDX;
		end else if ((p & M_PIC1) == P_PIC1) begin
			r = IO_PIC1;
		end else if ((p & M_TMR) == P_TMR) begin
			r = IO_TMR;
		end else if ((p & M_KBD) == P_KBD) begin
			r = IO_KBD;
		end else if ((p & M_NMI) == P_NMI) begin
			r = IO_NMI_SC;
		end else if ((p & M_RTC) == P_RTC) begin
			r = ((p & IO_ODD) != '0) ? IO_RTC_DAT : IO_RTC_IDX;
		end
		return r;
	endfunction : io_map

	// pure decode
	assign o_io = io_map(i_port);
endmodule : had_io_dec

// file: had_pkg.sv
// package: constants, types and carriers of the host address decoder
package had_pkg;
	// memory map
	localparam int          ADDR_W   = 36;
	localparam int          LOW_W    = 32;
	localparam logic [31:0] ISA_TOP  = 32'h000A_0000;
	localparam logic [31:0] VGA_HI   = 32'h000B_FFFF;
	localparam logic [31:0] SHD_LO   = 32'h000C_0000;
	localparam logic [31:0] BIOS_LO  = 32'h000F_0000;
	localparam logic [31:0] BIOS_HI  = 32'h000F_FFFF;
	localparam logic [31:0] MEM_TOP  = 32'h4000_0000;
	localparam int          SEG_SH   = 14;
	localparam int          NBLK     = 13;
	localparam logic [3:0]  BIOS_BLK = 4'hC;
	// reset values
	localparam logic [31:0] WIN_BASE_RST = 32'h000A_0000;
	localparam logic [31:0] WIN_LIM_RST  = 32'h000B_FFFF;
	localparam logic [25:0] SHD_RST      = 26'h000_0000;
	localparam logic [7:0]  LEG_RST      = 8'h00;
	localparam int          NMI_BIT      = 7;
	// register offsets and fields
	localparam logic [31:0] REG_CTRL  = 32'h0000_0000;
	localparam logic [31:0] REG_WBASE = 32'h0000_0004;
	localparam logic [31:0] REG_WLIM  = 32'h0000_0008;
	localparam logic [31:0] REG_SHD   = 32'h0000_000C;
	localparam logic [31:0] REG_STAT  = 32'h0000_0010;
	localparam logic [31:0] REG_LEG   = 32'h0000_0014;
	localparam int          CTRL_EN   = 0;
	localparam int          NBYTE     = 4;
	localparam logic [1:0]  RESP_OK   = 2'h0;
	localparam logic [1:0]  RESP_ERR  = 2'h2;
	// legacy I/O ports and match masks
	localparam logic [15:0] IO_ODD   = 16'h0001;
	localparam logic [15:0] P_DMA1   = 16'h0000;
	localparam logic [15:0] M_DMA1   = 16'hFFE0;
	localparam logic [15:0] P_PIC1   = 16'h0020;
	localparam logic [15:0] M_PIC1   = 16'hFFE2;
	localparam logic [15:0] P_SIO    = 16'h002E;
	localparam logic [15:0] M_PAIR   = 16'hFFFE;
	localparam logic [15:0] P_TMR    = 16'h0040;
	localparam logic [15:0] M_TMR    = 16'hFFEC;
	localparam logic [15:0] P_KBD    = 16'h0060;
	localparam logic [15:0] M_KBD    = 16'hFFFB;
	localparam logic [15:0] P_NMI    = 16'h0061;
	localparam logic [15:0] M_NMI    = 16'hFFF9;
	localparam logic [15:0] P_RTC    = 16'h0070;
	localparam logic [15:0] M_RTC    = 16'hFFF8;

	typedef enum logic [2:0] {
		TGT_NONE = 3'b000,
		TGT_MAIN = 3'b001,
		TGT_PCI  = 3'b010,
		TGT_TERM = 3'b011,
		TGT_SMM  = 3'b100
	} had_tgt_t;

	typedef enum logic [3:0] {
		IO_NONE    = 4'b0000,
		IO_DMA1    = 4'b0001,
		IO_PIC1    = 4'b0010,
		IO_TMR     = 4'b0011,
		IO_SIO_IDX = 4'b0100,
		IO_SIO_DAT = 4'b0101,
		IO_KBD     = 4'b0110,
		IO_NMI_SC  = 4'b0111,
		IO_RTC_IDX = 4'b1000,
		IO_RTC_DAT = 4'b1001
	} had_io_t;

	typedef struct packed {
		logic              valid;
		logic              mem;
		logic              wr;
		logic              from_cpu;
		logic              qual_n;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} had_req_t;

	typedef struct packed {
		logic       valid;
		had_tgt_t   tgt;
		had_io_t    io;
		logic       host_fwd;
		logic       rd_vld;
		logic [7:0] rdata;
	} had_rsp_t;
endpackage : had_pkg

// file: had_top.sv
// host address decoder: memory claim, shadow routing, management window, I/O map
`timescale 1ns/1ns
module had_top (
	input  wire logic               i_clk,
	input  wire logic               i_reset,
	input  had_pkg::had_req_t       i_req,
	output had_pkg::had_rsp_t       o_rsp,
	output logic                    o_nmi_mask,
	output logic [6:0]              o_rtc_index,
	input  wire logic               i_awvalid,
	input  wire logic [31:0]        i_awaddr,
	output logic                    o_awready,
	input  wire logic               i_wvalid,
	input  wire logic [31:0]        i_wdata,
	input  wire logic [3:0]         i_wstrb,
	output logic                    o_wready,
	output logic                    o_bvalid,
	output logic [1:0]              o_bresp,
	input  wire logic               i_bready,
	input  wire logic               i_arvalid,
	input  wire logic [31:0]        i_araddr,
	output logic                    o_arready,
	output logic                    o_rvalid,
	output logic [31:0]             o_rdata,
	output logic [1:0]              o_rresp,
	input  wire logic               i_rready
);
	import had_pkg::*;

	// configuration and state
	logic              en_r;
	logic [31:0]       wbase_r;
	logic [31:0]       wlim_r;
	logic [NBLK*2-1:0] shd_r;
	logic [7:0]        leg_r;
	logic [15:0]       term_cnt_r;
	had_tgt_t          last_tgt_r;
	// bus slave state
	logic              aw_got_r;
	logic              w_got_r;
	logic [31:0]       aw_a_r;
	logic [31:0]       w_d_r;
	logic [3:0]        w_s_r;
	logic              wr_go;
	logic [31:0]       rd_val;
	logic              rd_ok;
	logic [31:0]       ctrl_m;
	logic [31:0]       shd_m;
	// decode wires
	logic [31:0]       a;
	logic              hi;
	logic              in_win;
	logic              in_shd;
	logic [3:0]        shd_i;
	logic              shd_ram;
	logic              shd_any;
	had_io_t           io;
	had_tgt_t          d_tgt;
	logic              d_fwd;
	logic              d_rv;
	logic [7:0]        d_rd;

	// known register offsets
	function automatic logic reg_ok(input logic [31:0] ad);
		return ad == REG_CTRL || ad == REG_WBASE || ad == REG_WLIM ||
			ad == REG_SHD || ad == REG_STAT || ad == REG_LEG;
	endfunction : reg_ok

	// byte-lane merge of a write
	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < NBYTE; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	// block index inside the shadowable area
	function automatic logic [3:0] blk_of(input logic [31:0] ad);
		logic [31:0] off;
		off = (ad - SHD_LO) >> SEG_SH;
		return (ad >= BIOS_LO) ? BIOS_BLK : off[3:0];
	endfunction : blk_of

	// port decode
	had_io_dec u_io (
		.i_port (i_req.addr[15:0]),
		.o_io   (io)
	);

	// address qualifiers
	assign a       = i_req.addr[LOW_W-1:0];
	assign hi      = |i_req.addr[ADDR_W-1:LOW_W];
	assign in_win  = (a >= wbase_r) && (a <= wlim_r);
	assign in_shd  = (a >= SHD_LO) && (a <= BIOS_HI);
	assign shd_i   = blk_of(a);
	assign shd_ram = shd_r[{shd_i, i_req.wr}];
	assign shd_any = |shd_r[{shd_i, 1'b0} +: 2];

	// memory and I/O routing decision
	always_comb begin
		d_tgt = TGT_NONE;
		d_fwd = 1'b0;
		d_rv  = 1'b0;
		d_rd  = '0;
		if (!i_req.mem) begin
			d_tgt = (io == IO_NONE) ? TGT_NONE : TGT_PCI;
			if (io == IO_RTC_IDX && !i_req.wr) begin
				d_rv = 1'b1;
				d_rd = leg_r;
			end
		end else if (hi) begin
			d_tgt = TGT_TERM;
			d_rv  = !i_req.wr;
		end else if (i_req.from_cpu && !i_req.qual_n && in_win) begin
			d_tgt = en_r ? TGT_SMM : TGT_NONE;
		end else if (a < ISA_TOP) begin
			d_tgt = TGT_MAIN;
		end else if (a <= VGA_HI) begin
			d_tgt = TGT_PCI;
		end else if (in_shd) begin
			d_tgt = shd_ram ? TGT_MAIN : TGT_PCI;
		end else if (a < MEM_TOP) begin
			d_tgt = TGT_MAIN;
		end else begin
			d_tgt = TGT_PCI;
		end
		// bus-master snoop onto processor bus, never for shadowed blocks
		if (i_req.mem && !i_req.from_cpu && d_tgt == TGT_MAIN && !(in_shd && shd_any)) begin
			d_fwd = 1'b1;
		end
	end

	// registered answer one cycle after the request
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_rsp <= '0;
		end else begin
			o_rsp.valid    <= i_req.valid;
			o_rsp.tgt      <= d_tgt;
			o_rsp.io       <= i_req.mem ? IO_NONE : io;
			o_rsp.host_fwd <= i_req.valid && d_fwd;
			o_rsp.rd_vld   <= i_req.valid && d_rv;
			o_rsp.rdata    <= d_rv ? d_rd : '0;
		end
	end

	// index/mask port written by I/O cycles
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			leg_r <= LEG_RST;
		end else if (i_req.valid && !i_req.mem && i_req.wr && io == IO_RTC_IDX) begin
			leg_r <= i_req.wdata;
		end
	end

	assign o_nmi_mask  = leg_r[NMI_BIT];
	assign o_rtc_index = leg_r[NMI_BIT-1:0];

	// terminated-access counter and last target
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			term_cnt_r <= '0;
			last_tgt_r <= TGT_NONE;
		end else if (i_req.valid) begin
			last_tgt_r <= d_tgt;
			if (d_tgt == TGT_TERM && term_cnt_r != '1) begin
				term_cnt_r <= term_cnt_r + 16'h0001;
			end
		end
	end

	// write address and data capture, either order
	assign o_awready = !aw_got_r && !o_bvalid;
	assign o_wready  = !w_got_r && !o_bvalid;
	assign wr_go     = aw_got_r && w_got_r && !o_bvalid;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			aw_a_r   <= '0;
			w_d_r    <= '0;
			w_s_r    <= '0;
		end else if (wr_go) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_got_r <= 1'b1;
				aw_a_r   <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_got_r <= 1'b1;
				w_d_r   <= i_wdata;
				w_s_r   <= i_wstrb;
			end
		end
	end

	// write response
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_bvalid <= 1'b0;
			o_bresp  <= RESP_OK;
		end else if (wr_go) begin
			o_bvalid <= 1'b1;
			o_bresp  <= reg_ok(aw_a_r) ? RESP_OK : RESP_ERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// merged images of the partial-width registers, selected below
	assign ctrl_m = wmerge({31'h0000_0000, en_r}, w_d_r, w_s_r);
	assign shd_m  = wmerge({6'h00, shd_r}, w_d_r, w_s_r);

	// configuration registers
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			en_r    <= 1'b0;
			wbase_r <= WIN_BASE_RST;
			wlim_r  <= WIN_LIM_RST;
			shd_r   <= SHD_RST;
		end else if (wr_go) begin
			unique case (aw_a_r)
				REG_CTRL: begin
					en_r <= ctrl_m[CTRL_EN];
				end
				REG_WBASE: begin
					wbase_r <= wmerge(wbase_r, w_d_r, w_s_r);
				end
				REG_WLIM: begin
					wlim_r <= wmerge(wlim_r, w_d_r, w_s_r);
				end
				REG_SHD: begin
					shd_r <= shd_m[NBLK*2-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// read mux
	always_comb begin
		rd_val = '0;
		rd_ok  = 1'b1;
		unique case (i_araddr)
			REG_CTRL:  rd_val = {31'h0000_0000, en_r};
			REG_WBASE: rd_val = wbase_r;
			REG_WLIM:  rd_val = wlim_r;
			REG_SHD:   rd_val = {6'h00, shd_r};
			REG_STAT:  rd_val = {13'h0000, last_tgt_r, term_cnt_r};
			REG_LEG:   rd_val = {24'h00_0000, leg_r};
			default:   rd_ok  = 1'b0;
		endcase
	end

	assign o_arready = !o_rvalid;

	// read response
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_rvalid <= 1'b0;
			o_rdata  <= '0;
			o_rresp  <= RESP_OK;
		end else if (i_arvalid && o_arready) begin
			o_rvalid <= 1'b1;
			o_rdata  <= rd_val;
			o_rresp  <= rd_ok ? RESP_OK : RESP_ERR;
		end else if (i_rready) begin
			o_rvalid <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_mreq;
		i_req.valid && i_req.mem;
	endsequence

	sequence s_qual_win;
		s_mreq ##0 (i_req.from_cpu && !i_req.qual_n && !hi && in_win);
	endsequence

	sequence s_cpu_shd;
		s_mreq ##0 (i_req.from_cpu && !hi && in_shd && (i_req.qual_n || !in_win));
	endsequence

	sequence s_wr_pair;
		aw_got_r && w_got_r && !o_bvalid;
	endsequence

	AST_HIGH_TERM: assert property (s_mreq ##0 hi |=> o_rsp.tgt == TGT_TERM)
		else $error("high access not terminated");
	AST_TERM_ZERO: assert property (s_mreq ##0 (hi && !i_req.wr) |=> o_rsp.rd_vld && o_rsp.rdata == 8'h00)
		else $error("terminated read not zero");
	AST_LOW_NOTERM: assert property (s_mreq ##0 !hi |=> o_rsp.tgt != TGT_TERM)
		else $error("low access terminated");
	AST_SHD_ROUTE: assert property (s_cpu_shd |=> o_rsp.tgt == ($past(shd_ram) ? TGT_MAIN : TGT_PCI))
		else $error("shadow block misrouted");
	AST_SHD_NOFWD: assert property (s_mreq ##0 (!i_req.from_cpu && in_shd && shd_any) |=> !o_rsp.host_fwd)
		else $error("shadowed block seen on processor bus");
	AST_SMM_OFF: assert property (s_qual_win ##0 !en_r |=> o_rsp.tgt == TGT_NONE)
		else $error("disabled window claimed");
	AST_SMM_ON: assert property (s_qual_win ##0 en_r |=> o_rsp.tgt == TGT_SMM)
		else $error("enabled window not claimed");
	AST_SMM_UNQUAL: assert property (s_mreq ##0 (i_req.qual_n && !hi && a >= ISA_TOP && a <= VGA_HI)
		|=> o_rsp.tgt == TGT_PCI)
		else $error("window decoded without qualifier");
	AST_IO_DMA: assert property (i_req.valid && !i_req.mem && i_req.addr[15:0] == 16'h0013
		|=> o_rsp.io == IO_DMA1)
		else $error("dma alias not decoded");
	AST_IO_PIC: assert property (i_req.valid && !i_req.mem && i_req.addr[15:0] == 16'h003D
		|=> o_rsp.io == IO_PIC1)
		else $error("interrupt controller alias not decoded");
	AST_IO_GAP: assert property (i_req.valid && !i_req.mem && i_req.addr[15:0] == 16'h0048
		|=> o_rsp.io == IO_NONE)
		else $error("unassigned timer gap decoded");
	AST_IO_NMI: assert property (i_req.valid && !i_req.mem && i_req.addr[15:0] == 16'h0067
		|=> o_rsp.io == IO_NMI_SC)
		else $error("nmi alias not decoded");
	AST_LEG_WR: assert property (i_req.valid && !i_req.mem && i_req.wr && io == IO_RTC_IDX
		|=> o_nmi_mask == $past(i_req.wdata[NMI_BIT]) && o_rtc_index == $past(i_req.wdata[6:0]))
		else $error("nmi mask or clock index not held");
	AST_RST_DEF: assert property ($fell(i_reset) |-> !en_r && wbase_r == WIN_BASE_RST
		&& wlim_r == WIN_LIM_RST && shd_r == SHD_RST)
		else $error("reset defaults wrong");
	AST_AXI_B: assert property (s_wr_pair |=> o_bvalid && !o_awready && !o_wready)
		else $error("write response missing");
	AST_AXI_R: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
		else $error("read response missing");
	AST_IO_SIO: assert property (i_req.valid && !i_req.mem && i_req.addr[15:0] == 16'h002F
		|=> o_rsp.io == IO_SIO_DAT)
		else $error("super io data port not decoded");
	AST_IO_TMR: assert property (i_req.valid && !i_req.mem && i_req.addr[15:0] == 16'h0052
		|=> o_rsp.io == IO_TMR)
		else $error("timer alias not decoded");
endmodule : had_top

// file: had_top_tb.sv
// self-checking bench for the host address decoder
`timescale 1ns/1ns
module had_top_tb;
	import had_pkg::*;
	logic        i_clk   = 1'b0;
	logic        i_reset = 1'b1;
	had_req_t    req;
	had_rsp_t    rsp;
	logic        nmi_mask;
	logic [6:0]  rtc_index;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic [3:0]  wstrb = 4'hF;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          err_count = 0;
	int          n_checks  = 0;

	// 50 MHz clock
	always #10 i_clk = ~i_clk;

	// far-side master and the block
	had_bus_master had_bus_master_i (.i_clk(i_clk), .o_req(req));
	had_top had_top_i (.i_clk(i_clk), .i_reset(i_reset), .i_req(req), .o_rsp(rsp), .o_nmi_mask(nmi_mask),
		.o_rtc_index(rtc_index), .i_awvalid(awvalid), .i_awaddr(awaddr), .o_awready(awready), .i_wvalid(wvalid),
		.i_wdata(wdata), .i_wstrb(wstrb), .o_wready(wready), .o_bvalid(bvalid), .o_bresp(bresp), .i_bready(bready),
		.i_arvalid(arvalid), .i_araddr(araddr), .o_arready(arready), .o_rvalid(rvalid), .o_rdata(rdata),
		.o_rresp(rresp), .i_rready(rready));

	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [35:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// a bus wait that ran out ends the run
	task automatic tmo(input logic ok);
		chk(ok, 1'b1);
		if (ok !== 1'b1) begin
			wrap_up();
		end
	endtask : tmo

	task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge i_clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		tmo(bvalid);
		bready <= 1'b0;
		chk(bresp, er);
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] a, e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge i_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		tmo(rvalid);
		rready <= 1'b0;
		chk(rdata, e);
		chk(rresp, er);
	endtask : axi_rd

	// one memory request and its claim
	task automatic mchk(input logic wr, cpu, qn, input logic [35:0] a, input had_tgt_t t, input logic fwd);
		had_bus_master_i.issue(1'b1, wr, cpu, qn, a, 8'h5A, 0);
		chk(rsp.valid, 1'b1);
		chk(rsp.tgt, t);
		chk(rsp.host_fwd, fwd);
	endtask : mchk

	task automatic t_term();
		mchk(1'b0, 1'b1, 1'b1, 36'h1_0000_0000, TGT_TERM, 1'b0);
		chk(rsp.rd_vld, 1'b1);
		chk(rsp.rdata, 8'h00);
		mchk(1'b1, 1'b1, 1'b1, 36'hF_FFFF_FFFF, TGT_TERM, 1'b0);
		mchk(1'b0, 1'b0, 1'b1, 36'h8_000A_0000, TGT_TERM, 1'b0);
		chk(rsp.rdata, 8'h00);
		mchk(1'b0, 1'b1, 1'b1, 36'h0_FFFF_FFFF, TGT_PCI, 1'b0);
	endtask : t_term

	task automatic t_smm();
		axi_rd(REG_CTRL, 32'h0, RESP_OK);
		axi_rd(REG_WBASE, 32'h000A_0000, RESP_OK);
		axi_rd(REG_WLIM, 32'h000B_FFFF, RESP_OK);
		mchk(1'b0, 1'b1, 1'b0, 36'h0A_0000, TGT_NONE, 1'b0);
		mchk(1'b0, 1'b1, 1'b1, 36'h0A_0000, TGT_PCI, 1'b0);
		axi_wr(REG_CTRL, 32'h1, RESP_OK);
		mchk(1'b0, 1'b1, 1'b0, 36'h0B_FFFF, TGT_SMM, 1'b0);
		mchk(1'b1, 1'b1, 1'b1, 36'h0B_0000, TGT_PCI, 1'b0);
		axi_wr(REG_WBASE, 32'h0030_0000, RESP_OK);
		axi_wr(REG_WLIM, 32'h0030_FFFF, RESP_OK);
		mchk(1'b1, 1'b1, 1'b0, 36'h30_0000, TGT_SMM, 1'b0);
		mchk(1'b0, 1'b1, 1'b0, 36'h31_0000, TGT_MAIN, 1'b0);
		mchk(1'b0, 1'b1, 1'b0, 36'h0A_0000, TGT_PCI, 1'b0);
		mchk(1'b0, 1'b1, 1'b1, 36'h30_8000, TGT_MAIN, 1'b0);
		axi_wr(REG_CTRL, 32'h0, RESP_OK);
		mchk(1'b0, 1'b1, 1'b0, 36'h30_FFFF, TGT_NONE, 1'b0);
		axi_wr(32'h0000_0040, 32'h1, RESP_ERR);
		axi_rd(32'h0000_0044, 32'h0, RESP_ERR);
	endtask : t_smm

	task automatic t_shadow();
		mchk(1'b0, 1'b1, 1'b1, 36'h0F_0000, TGT_PCI, 1'b0);
		mchk(1'b1, 1'b1, 1'b1, 36'h0F_FFFF, TGT_PCI, 1'b0);
		axi_wr(REG_SHD, 32'h0200_0000, RESP_OK);
		mchk(1'b0, 1'b1, 1'b1, 36'h0F_8000, TGT_PCI, 1'b0);
		mchk(1'b1, 1'b1, 1'b1, 36'h0F_8000, TGT_MAIN, 1'b0);
		axi_wr(REG_SHD, 32'h0100_0001, RESP_OK);
		mchk(1'b0, 1'b1, 1'b1, 36'h0F_0000, TGT_MAIN, 1'b0);
		mchk(1'b1, 1'b1, 1'b1, 36'h0F_0000, TGT_PCI, 1'b0);
		mchk(1'b0, 1'b1, 1'b1, 36'h0C_3FFF, TGT_MAIN, 1'b0);
		mchk(1'b0, 1'b1, 1'b1, 36'h0C_4000, TGT_PCI, 1'b0);
		mchk(1'b0, 1'b0, 1'b1, 36'h0F_0000, TGT_MAIN, 1'b0);
		mchk(1'b0, 1'b0, 1'b1, 36'h10_0000, TGT_MAIN, 1'b1);
	endtask : t_shadow

	task automatic t_io();
		logic [15:0] pt [20] = '{16'h0000, 16'h000F, 16'h001F, 16'h0020, 16'h0021, 16'h003D, 16'h0022, 16'h002E,
			16'h002F, 16'h0040, 16'h0053, 16'h0044, 16'h0054, 16'h0060, 16'h0061, 16'h0067, 16'h0062, 16'h0076,
			16'h0077, 16'h0078};
		had_io_t ex [20] = '{IO_DMA1, IO_DMA1, IO_DMA1, IO_PIC1, IO_PIC1, IO_PIC1, IO_NONE, IO_SIO_IDX, IO_SIO_DAT,
			IO_TMR, IO_TMR, IO_NONE, IO_NONE, IO_KBD, IO_NMI_SC, IO_NMI_SC, IO_NONE, IO_RTC_IDX, IO_RTC_DAT, IO_NONE};
		for (int k = 0; k < 20; k++) begin
			had_bus_master_i.issue(1'b0, 1'b0, 1'b1, 1'b1, {20'h0, pt[k]}, 8'h00, k % 3);
			chk(rsp.io, ex[k]);
			chk(rsp.tgt, (ex[k] == IO_NONE) ? TGT_NONE : TGT_PCI);
		end
	endtask : t_io

	task automatic t_latch();
		had_bus_master_i.issue(1'b0, 1'b1, 1'b1, 1'b1, 36'h0074, 8'hC5, 0);
		@(posedge i_clk);
		#1;
		chk(nmi_mask, 1'b1);
		chk(rtc_index, 7'h45);
		had_bus_master_i.issue(1'b0, 1'b1, 1'b1, 1'b1, 36'h0071, 8'h00, 0);
		had_bus_master_i.issue(1'b0, 1'b0, 1'b1, 1'b1, 36'h0076, 8'h00, 1);
		chk(rsp.rd_vld, 1'b1);
		chk(rsp.rdata, 8'hC5);
		axi_rd(REG_LEG, 32'h0000_00C5, RESP_OK);
		had_bus_master_i.issue(1'b0, 1'b1, 1'b1, 1'b1, 36'h0070, 8'h3A, 0);
		@(posedge i_clk);
		#1;
		chk(nmi_mask, 1'b0);
		chk(rtc_index, 7'h3A);
	endtask : t_latch

	// main sequence, with a second reset in mid-run
	initial begin
		repeat (8) @(posedge i_clk);
		i_reset <= 1'b0;
		#1;
		chk(nmi_mask, 1'b0);
		chk(rsp.valid, 1'b0);
		t_term();
		t_smm();
		t_shadow();
		t_io();
		t_latch();
		axi_wr(REG_CTRL, 32'h1, RESP_OK);
		@(posedge i_clk);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_reset <= 1'b0;
		axi_rd(REG_CTRL, 32'h0, RESP_OK);
		axi_rd(REG_WBASE, 32'h000A_0000, RESP_OK);
		mchk(1'b0, 1'b1, 1'b1, 36'h0F_0000, TGT_PCI, 1'b0);
		wrap_up();
	end

	// overall watchdog
	initial begin
		#1000000;
		chk(1'b0, 1'b1);
		wrap_up();
	end
endmodule : had_top_tb
